//--- src/fsrs_opcode_shift.sv
// Collects the instruction byte of each chip-select frame, one line per edge
// in single-line mode or a nibble per edge in quad-instruction mode.
// Assumes synchronised pins and a serial clock well below core_clk / 6.
`timescale 1ns/1ns
`default_nettype none
module fsrs_opcode_shift
  import fsrs_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io,
  input wire logic quad_mode,
  output logic frame_done,
  output logic frame_ok,
  output logic [7:0] frame_code
);

  logic sclk_prev_q;
  logic cs_prev_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;

  wire cs_fall = cs_prev_q & ~cs_n;
  wire cs_rise = ~cs_prev_q & cs_n;
  wire sclk_rise = ~sclk_prev_q & sclk & ~cs_n;
  wire room = bit_cnt_q < OP_BITS;
  wire [3:0] step = quad_mode ? QUAD_STEP : SINGLE_STEP;
  wire [7:0] shift_d = quad_mode ? {shift_q[3:0], io} : {shift_q[6:0], io[0]};

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      bit_cnt_q <= '0;
      shift_q <= '0;
    end else begin
      sclk_prev_q <= sclk;
      cs_prev_q <= cs_n;
      if (cs_fall) begin
        bit_cnt_q <= '0;
      end else if (sclk_rise && room) begin
        bit_cnt_q <= bit_cnt_q + step;
        shift_q <= shift_d;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      frame_done <= 1'b0;
      frame_ok <= 1'b0;
      frame_code <= '0;
    end else begin
      frame_done <= cs_rise;
      frame_ok <= cs_rise && !room;
      if (cs_rise) begin
        frame_code <= shift_q;
      end
    end
  end

endmodule : fsrs_opcode_shift
`default_nettype wire

//--- src/fsrs_pin_sync.sv
// Three-stage synchroniser for pins arriving from outside the core clock.
// The clean level moves only when stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module fsrs_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] clean
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          s1_q[gi] <= INIT[gi];
          s2_q[gi] <= INIT[gi];
          s3_q[gi] <= INIT[gi];
          clean[gi] <= INIT[gi];
        end else begin
          s1_q[gi] <= pin_in[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            clean[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate

endmodule : fsrs_pin_sync
`default_nettype wire

//--- src/fsrs_pkg.sv
// Constants for the flash software reset sequencer: opcodes, register map,
// reset values and timing.
// Assumes a 250 MHz core clock and 32-bit APB register access.
package fsrs_pkg;

  // Sequencer states, Gray coded along idle -> armed -> recovering
  typedef enum logic [1:0] {
    FSRS_IDLE  = 2'h0,
    FSRS_ARMED = 2'h1,
    FSRS_RECOV = 2'h3
  } fsrs_state_e;

  localparam logic [7:0] OPC_ARM = 8'h66;
  localparam logic [7:0] OPC_EXEC = 8'h99;
  localparam logic [3:0] OP_BITS = 4'h8;
  localparam logic [3:0] QUAD_STEP = 4'h4;
  localparam logic [3:0] SINGLE_STEP = 4'h1;

  // Recovery interval: 30 us at 4 ns per cycle, rounded up
  localparam int RST_TIME_NS = 30000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int RST_WAIT_CYC = (RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RCNT_W = 16;

  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STAT = 12'h004;
  localparam logic [11:0] OFS_RDPAR = 12'h008;
  localparam logic [11:0] OFS_CRMODE = 12'h00c;
  localparam logic [11:0] OFS_WRAP = 12'h010;
  localparam logic [11:0] OFS_VSTAT = 12'h014;
  localparam logic [11:0] OFS_LAST = 12'h018;

  // Field positions
  localparam int CTRL_QUAD = 0;
  localparam int CTRL_WEL = 1;
  localparam int CTRL_SUS = 2;
  localparam int STAT_ARMED = 0;
  localparam int STAT_RECOV = 1;
  localparam int STAT_REJ_LO = 8;

  // Power-on values of the volatile settings
  localparam logic RST_QUAD = 1'h0;
  localparam logic RST_WEL = 1'h0;
  localparam logic RST_SUS = 1'h0;
  localparam logic [7:0] RST_RDPAR = 8'h00;
  localparam logic [7:0] RST_CRMODE = 8'h00;
  localparam logic [2:0] RST_WRAP = 3'h0;
  localparam logic [7:0] RST_VSTAT = 8'h00;

endpackage : fsrs_pkg

//--- src/fsrs_top.sv
// Software reset sequencer of the serial flash command port, with the
// volatile settings it restores and an APB register window onto them.
// Assumes serial pins asynchronous to core_clk and an APB master on core_clk.
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module fsrs_top
  import fsrs_pkg::*;
#(
  parameter int RST_CYCLES = RST_WAIT_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic [3:0] spi_io,
  output logic abort_ops,
  output logic reset_busy,
  output logic cmd_strobe,
  output logic [7:0] cmd_code,
  output logic quad_instruction_mode
);

  fsrs_state_e st_q;
  fsrs_state_e st_d;
  logic [RCNT_W-1:0] rcnt_q;
  logic write_enable_latch;
  logic suspend_status_flag;
  logic [7:0] read_parameter_field;
  logic [7:0] continuous_read_mode_field;
  logic [2:0] wrap_setting_field;
  logic [7:0] vstat_q;
  logic [7:0] reject_cnt_q;
  logic [31:0] prdata_q;
  logic sclk_c;
  logic cs_n_c;
  logic [3:0] io_c;
  logic frame_done;
  logic frame_ok;
  logic [7:0] frame_code;

  fsrs_pin_sync #(
    .WIDTH(6),
    .INIT(6'h02)
  ) u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .pin_in({spi_io, spi_cs_n, spi_sclk}),
    .clean({io_c, cs_n_c, sclk_c})
  );

  fsrs_opcode_shift u_shift (
    .core_clk(core_clk),
    .nrst(nrst),
    .sclk(sclk_c),
    .cs_n(cs_n_c),
    .io(io_c),
    .quad_mode(quad_instruction_mode),
    .frame_done(frame_done),
    .frame_ok(frame_ok),
    .frame_code(frame_code)
  );

  // Command classification; short frames carry no instruction and are ignored
  wire recovering = st_q == FSRS_RECOV;
  wire armed = st_q == FSRS_ARMED;
  wire cmd_in = frame_done & frame_ok;
  wire cmd_rejected = cmd_in & recovering;
  wire cmd_live = cmd_in & ~recovering;
  wire is_arm = frame_code == OPC_ARM;
  wire is_exec = frame_code == OPC_EXEC;
  wire accept_rst = cmd_live & armed & is_exec;
  wire rcnt_zero = rcnt_q == '0;
  wire [RCNT_W-1:0] rcnt_load = RCNT_W'(RST_CYCLES - 1);

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      FSRS_IDLE: begin
        if (cmd_live && is_arm) begin
          st_d = FSRS_ARMED;
        end
      end
      FSRS_ARMED: begin
        if (cmd_live) begin
          if (is_exec) begin
            st_d = FSRS_RECOV;
          end else if (!is_arm) begin
            st_d = FSRS_IDLE;
          end
        end
      end
      FSRS_RECOV: begin
        if (rcnt_zero) begin
          st_d = FSRS_IDLE;
        end
      end
      default: begin
        st_d = FSRS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= FSRS_IDLE;
      rcnt_q <= '0;
    end else begin
      st_q <= st_d;
      if (accept_rst) begin
        rcnt_q <= rcnt_load;
      end else if (recovering && !rcnt_zero) begin
        rcnt_q <= rcnt_q - 1'b1;
      end
    end
  end

  // Forward non-reset commands to the rest of the device; reject while recovering
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      abort_ops <= 1'b0;
      cmd_strobe <= 1'b0;
      cmd_code <= '0;
      reject_cnt_q <= '0;
    end else begin
      abort_ops <= accept_rst;
      cmd_strobe <= cmd_live & ~is_arm & ~is_exec;
      if (cmd_live && !is_arm && !is_exec) begin
        cmd_code <= frame_code;
      end
      if (cmd_rejected && reject_cnt_q != 8'hff) begin
        reject_cnt_q <= reject_cnt_q + 8'h01;
      end
    end
  end

  assign reset_busy = recovering;

  // APB decode; zero wait states, read data captured in the setup cycle
  wire sel_ctrl = paddr == OFS_CTRL;
  wire sel_stat = paddr == OFS_STAT;
  wire sel_rdpar = paddr == OFS_RDPAR;
  wire sel_crmode = paddr == OFS_CRMODE;
  wire sel_wrap = paddr == OFS_WRAP;
  wire sel_vstat = paddr == OFS_VSTAT;
  wire sel_last = paddr == OFS_LAST;
  wire mapped = sel_ctrl | sel_stat | sel_rdpar | sel_crmode | sel_wrap | sel_vstat | sel_last;
  wire wr_ok = psel & penable & pwrite & mapped;
  wire [31:0] ctrl_word = {29'h0, suspend_status_flag, write_enable_latch,
                           quad_instruction_mode};
  wire [31:0] stat_word = {16'h0, reject_cnt_q, 6'h0, recovering, armed};
  wire [31:0] rd_word =
      sel_ctrl ? ctrl_word :
      sel_stat ? stat_word :
      sel_rdpar ? {24'h0, read_parameter_field} :
      sel_crmode ? {24'h0, continuous_read_mode_field} :
      sel_wrap ? {29'h0, wrap_setting_field} :
      sel_vstat ? {24'h0, vstat_q} :
      sel_last ? {24'h0, cmd_code} : 32'h0;

  assign pready = psel & penable;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_q;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_q <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rd_word;
    end
  end

  // Volatile settings; an accepted reset beats a software write in the same cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      quad_instruction_mode <= RST_QUAD;
      write_enable_latch <= RST_WEL;
      suspend_status_flag <= RST_SUS;
    end else if (accept_rst) begin
      quad_instruction_mode <= RST_QUAD;
      write_enable_latch <= RST_WEL;
      suspend_status_flag <= RST_SUS;
    end else if (wr_ok && sel_ctrl) begin
      quad_instruction_mode <= pwdata[CTRL_QUAD];
      write_enable_latch <= pwdata[CTRL_WEL];
      suspend_status_flag <= pwdata[CTRL_SUS];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      read_parameter_field <= RST_RDPAR;
      continuous_read_mode_field <= RST_CRMODE;
      wrap_setting_field <= RST_WRAP;
      vstat_q <= RST_VSTAT;
    end else if (accept_rst) begin
      read_parameter_field <= RST_RDPAR;
      continuous_read_mode_field <= RST_CRMODE;
      wrap_setting_field <= RST_WRAP;
      vstat_q <= RST_VSTAT;
    end else if (wr_ok) begin
      if (sel_rdpar) begin
        read_parameter_field <= pwdata[7:0];
      end
      if (sel_crmode) begin
        continuous_read_mode_field <= pwdata[7:0];
      end
      if (sel_wrap) begin
        wrap_setting_field <= pwdata[2:0];
      end
      if (sel_vstat) begin
        vstat_q <= pwdata[7:0];
      end
    end
  end

  // Helper for the interval check: cycles spent recovering so far
  logic [RCNT_W-1:0] hold_cnt_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hold_cnt_q <= '0;
    end else if (recovering) begin
      hold_cnt_q <= hold_cnt_q + 1'b1;
    end else begin
      hold_cnt_q <= '0;
    end
  end

  abort_pulse_a : assert property (
    @(posedge core_clk) disable iff (!nrst)
    accept_rst |=> abort_ops && reset_busy ##1 !abort_ops)
    else $error("abort pulse missing after accepted reset");

  volatile_clear_a : assert property (
    @(posedge core_clk) disable iff (!nrst)
    $rose(abort_ops) |-> !write_enable_latch && !suspend_status_flag &&
      !quad_instruction_mode && read_parameter_field == RST_RDPAR &&
      continuous_read_mode_field == RST_CRMODE && wrap_setting_field == RST_WRAP &&
      vstat_q == RST_VSTAT)
    else $error("volatile settings not restored");

  arm_decode_a : assert property (
    @(posedge core_clk) disable iff (!nrst)
    (cmd_in && !recovering && frame_code == OPC_ARM) |=> armed)
    else $error("arm instruction not decoded");

  exec_order_a : assert property (
    @(posedge core_clk) disable iff (!nrst)
    $rose(reset_busy) |-> $past(st_q) == FSRS_ARMED && $past(frame_code) == 8'h99 &&
      $past(frame_done))
    else $error("reset without arm then exec");

  disarm_other_a : assert property (
    @(posedge core_clk) disable iff (!nrst)
    (cmd_live && frame_code != 8'h66 && frame_code != 8'h99) |=> !armed && !reset_busy)
    else $error("still armed after other command");

  recov_length_a : assert property (
    @(posedge core_clk) disable iff (!nrst)
    $fell(reset_busy) |-> $past(hold_cnt_q) == RST_CYCLES - 1)
    else $error("recovery interval wrong length");

  recov_reject_a : assert property (
    @(posedge core_clk) disable iff (!nrst)
    cmd_rejected |=> !cmd_strobe && !abort_ops && !armed)
    else $error("command accepted during recovery");

  // Counter is left alone by the software reset so lost commands stay visible
  reject_count_a : assert property (
    @(posedge core_clk) disable iff (!nrst)
    (cmd_rejected && reject_cnt_q != 8'hff) |=> reject_cnt_q == $past(reject_cnt_q) + 8'h01)
    else $error("rejected command not counted");

  rearm_needed_a : assert property (
    @(posedge core_clk) disable iff (!nrst)
    $fell(reset_busy) |-> !armed ##1 (!armed || $past(cmd_live && is_arm)))
    else $error("armed state survived reset");

endmodule : fsrs_top
`default_nettype wire

//--- tb/flash_software_reset_sequencer_bench.sv
// Self-checking bench of the software reset sequencer over APB and serial pins.
// Assumes a 250 MHz core clock and the host model driving the serial side.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module flash_software_reset_sequencer_bench;
  import fsrs_pkg::*;
  localparam int RCYC = 600;
  logic core_clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic sclk, cs_n, abort_ops, reset_busy, cmd_strobe, qmode;
  logic [3:0] io;
  logic [7:0] cmd_code;
  int n_mismatch = 0, cmp_count = 0, n_abort = 0, n_strobe = 0;
  int busy_run = 0, busy_len = 0, cyc = 0;

  fsrs_top #(.RST_CYCLES(RCYC)) u_dut (.core_clk(core_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_io(io),
    .abort_ops(abort_ops), .reset_busy(reset_busy), .cmd_strobe(cmd_strobe),
    .cmd_code(cmd_code), .quad_instruction_mode(qmode));
  fsrs_host_model u_host (.core_clk(core_clk), .sclk(sclk), .cs_n(cs_n), .io(io));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (abort_ops === 1'b1) n_abort++;
    if (cmd_strobe === 1'b1) n_strobe++;
    if (reset_busy === 1'b1) busy_run++;
    else if (busy_run != 0) begin
      busy_len = busy_run;
      busy_run = 0;
    end
    cyc++;
    // A hang counts against the run
    if (cyc == 40000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    // No limit of its own: if pready never rises, only the bench timeout ends this wait
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(nm, x, r)
  endtask : rd_chk

  task automatic wait_busy(input logic lvl);
    int k;
    k = 0;
    while (reset_busy !== lvl && k < 1000) begin
      @(posedge core_clk);
      k++;
    end
    `CHK("busy level", lvl, reset_busy)
    @(posedge core_clk);
  endtask : wait_busy

  task automatic t_regs();
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 7; i++) rd_chk("reset value", 12'(4 * i), 32'h0);
    apb(1'b0, 12'h01c, 32'h0, r, e);
    `CHK("unmapped err", 1'b1, e)
    apb(1'b1, 12'h002, 32'hff, r, e);
    `CHK("unaligned err", 1'b1, e)
    wr(OFS_STAT, 32'h3);
    rd_chk("stat ro", OFS_STAT, 32'h0);
  endtask : t_regs

  task automatic t_reset(input logic quad);
    int a0;
    wr(OFS_CTRL, {29'h0, 3'h6 | {2'h0, quad}});
    wr(OFS_RDPAR, 32'h5a);
    wr(OFS_CRMODE, 32'ha5);
    wr(OFS_WRAP, 32'h5);
    wr(OFS_VSTAT, 32'h3c);
    rd_chk("ctrl set", OFS_CTRL, {29'h0, 3'h6 | {2'h0, quad}});
    `CHK("quad on", quad, qmode)
    a0 = n_abort;
    u_host.send(OPC_ARM, quad);
    rd_chk("armed", OFS_STAT, 32'h1);
    u_host.send(OPC_EXEC, quad);
    wait_busy(1'b1);
    `CHK("abort pulse", a0 + 1, n_abort)
    `CHK("quad cleared", 1'b0, qmode)
    for (int i = 0; i < 6; i++) rd_chk("volatile", 12'(4 * i), i == 1 ? 32'h2 : 32'h0);
    wait_busy(1'b0);
    `CHK("busy length", RCYC, busy_len)
    rd_chk("disarmed", OFS_STAT, 32'h0);
  endtask : t_reset

  task automatic t_disarm();
    int a0, s0;
    a0 = n_abort;
    s0 = n_strobe;
    u_host.send(OPC_ARM, 1'b0);
    u_host.send(8'h03, 1'b0);
    `CHK("strobe", s0 + 1, n_strobe)
    `CHK("code", 8'h03, cmd_code)
    rd_chk("not armed", OFS_STAT, 32'h0);
    u_host.send(OPC_EXEC, 1'b0);
    `CHK("no reset", a0, n_abort)
    `CHK("no strobe", s0 + 1, n_strobe)
  endtask : t_disarm

  task automatic t_reject();
    int s0;
    u_host.send(OPC_ARM, 1'b0);
    u_host.send(OPC_EXEC, 1'b0);
    wait_busy(1'b1);
    s0 = n_strobe;
    u_host.send(8'h05, 1'b0);
    u_host.send(OPC_ARM, 1'b0);
    rd_chk("rejects", OFS_STAT, 32'h202);
    wait_busy(1'b0);
    `CHK("rejected", s0, n_strobe)
    u_host.send(OPC_EXEC, 1'b0);
    `CHK("arm refused", 1'b0, reset_busy)
  endtask : t_reject

  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge core_clk);
    t_regs();
    t_reset(1'b0);
    t_reset(1'b1);
    t_disarm();
    t_reject();
    final_report();
  end
endmodule : flash_software_reset_sequencer_bench
`default_nettype wire

//--- tb/fsrs_host_model.sv
// Host flash controller model: drives chip select, serial clock and data lines.
// Assumes core_clk is the bench clock; the serial clock stays high 4 core cycles and low 8.
`timescale 1ns/1ns
`default_nettype none
module fsrs_host_model (
  input wire logic core_clk,
  output logic sclk,
  output logic cs_n,
  output logic [3:0] io
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    io = 4'h0;
  end

  task automatic send(input logic [7:0] code, input logic quad);
    int n;
    n = quad ? 2 : 8;
    @(posedge core_clk);
    cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge core_clk);
      // Unused lines keep toggling so nothing leans on a stale value
      io <= quad ? code[7-4*i -: 4] : {~io[3:1], code[7-i]};
      repeat (4) @(posedge core_clk);
      sclk <= 1'b1;
      repeat (4) @(posedge core_clk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
    cs_n <= 1'b1;
    io <= ~io;
    // Inter-frame gap well above the synchroniser delay
    repeat (8) @(posedge core_clk);
  endtask : send
endmodule : fsrs_host_model
`default_nettype wire
